/* File: scbg_params.svh */
// constants of the serial card bus glue: port offsets, field positions, reset values
// assumes an eight-location i/o window decoded from host address lines a9..a3
// Functional notes
// RULE_01 - card answers exactly eight consecutive i/o addresses from the selected base
// RULE_02 - base can sit at any eight-aligned i/o location from 100 to 3f8 hex
// RULE_03 - seven switch positions compare a9..a3, position 1 against a9, low bits ignored
// RULE_04 - closed switch needs a 0 on its address line, open switch needs a 1
// RULE_05 - offsets 0..3 reach channel a data, a control, b data, b control
// RULE_06 - offset 4 reaches the board control/status port, not the serial controller
// RULE_07 - interrupt goes to exactly one selectable line: 2/9, 3, 4 or 5
// RULE_08 - normal mode drives the line alone; shared mode shares it, pull-down on one
// RULE_09 - half-duplex dma moves data one direction at a time per channel
// RULE_10 - full-duplex dma only on channel a, using host dma 1 and 3 together
// RULE_11 - two-channel dma puts a and b on different host dma channels
// RULE_12 - host dma acknowledge 1 or 3 goes to the serial channel assigned to it
// RULE_13 - channel b uses dma only half duplex and only with its enable routed
// RULE_14 - permanent-enable option keeps dma drivers on regardless of software bit
// RULE_15 - software-control option enables dma drivers only while bit 7 is set
// RULE_16 - with no driver option chosen, dma drivers stay off and no dma happens
// RULE_17 - power-on reset clears the software dma enable
// RULE_18 - permanent enable wins over any software clear of the dma enable bit
// RULE_19 - installer leaves all dma routing unselected when dma is not used
// RULE_20 - control/status write stores bit 7 as dma enable, 1 on, 0 off
// RULE_21 - bits 0,1 write terminal-ready a,b; reads return data-set-ready a,b
// RULE_22 - offsets 5..7 have no side effect and reads there drive no data
`ifndef SCBG_PARAMS_SVH
`define SCBG_PARAMS_SVH

`define SCBG_OFS_CHA_DATA 3'h0
`define SCBG_OFS_CHA_CTRL 3'h1
`define SCBG_OFS_CHB_DATA 3'h2
`define SCBG_OFS_CHB_CTRL 3'h3
`define SCBG_OFS_BOARD_CS 3'h4

`define SCBG_BIT_DTR_A 0
`define SCBG_BIT_DTR_B 1
`define SCBG_BIT_DMA_EN 7

`define SCBG_RST_DMA_EN 1'b0
`define SCBG_RST_DTR 1'b0

// a9..a8 of zero would fall below the lowest selectable base
`define SCBG_BASE_HI_NONE 2'h0

`endif

/* File: scbg_pkg.sv */
// types shared by the serial card bus glue
// assumes scbg_params.svh supplies the numeric constants
package scbg_pkg;

  typedef enum logic [1:0] {PH_IDLE, PH_READ, PH_HOLD} scbg_phase_t;

  typedef enum logic [3:0] {
    DM_NONE, DM_HALF_A1, DM_HALF_A3, DM_HALF_B1, DM_HALF_B3,
    DM_SPLIT_SPLIT_DMA_A_HIGH, DM_SPLIT_SPLIT_DMA_A_LOW, DM_FULL_RX1, DM_FULL_RX3
  } scbg_dma_mode_t;

  typedef struct packed {
    scbg_phase_t phase;
    logic [2:0] rd_ofs;
    logic [1:0] sc_addr;
    logic [7:0] sc_wdata;
    logic sc_wr;
    logic sc_rd;
    logic [7:0] data_out;
    logic data_oe;
    logic dtr_a;
    logic dtr_b;
    logic dma_en;
    logic drq1;
    logic drq3;
    logic drq1_oe;
    logic drq3_oe;
    logic dack_a;
    logic dack_b;
    logic [3:0] irq_out;
    logic [3:0] irq_oe;
    logic irq_pulldown_en;
  } scbg_state_t;

endpackage : scbg_pkg

/* File: scbg_sync.sv */
// two-stage synchroniser for a group of pin inputs
// assumes inputs are static or slow relative to clk; no bus coherence is promised
`timescale 1ns/100ps
module scbg_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pins in, synchronised out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } scbg_sync_t;

  scbg_sync_t s_r;
  scbg_sync_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.meta = d;
    s_nxt.stable = s_r.meta;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.stable;

endmodule : scbg_sync

/* File: scbg_glue.sv */
// host-bus glue of a two-channel serial adapter: window decode, port steering,
// board control/status port, interrupt line selection and dma routing/gating
// assumes the serial controller runs on clk; all host pins and straps are asynchronous
`timescale 1ns/100ps
`include "scbg_params.svh"
module scbg_glue (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // host i/o bus
  input wire logic [9:0] host_addr,
  input wire logic host_aen,
  input wire logic host_ior_n,
  input wire logic host_iow_n,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe,
  output logic card_hit,
  // board straps: 1 means jumper fitted or switch closed
  input wire logic [6:0] base_address_switch,
  input wire logic [3:0] irq_select_header,
  input wire logic irq_shared_sel,
  input wire logic [6:1] dma_ack_route_header,
  input wire logic [6:1] dma_request_route_header,
  input wire logic [1:0] dma_driver_gate_header,
  // serial controller port
  output logic sc_wr,
  output logic sc_rd,
  output logic [1:0] sc_addr,
  output logic [7:0] sc_wdata,
  input wire logic [7:0] sc_rdata,
  input wire logic sc_irq,
  input wire logic sc_req_a,
  input wire logic sc_dtr_req_a,
  input wire logic sc_req_b,
  output logic sc_dack_a,
  output logic sc_dack_b,
  // modem lines
  output logic dtr_a,
  output logic dtr_b,
  input wire logic dsr_a,
  input wire logic dsr_b,
  // host interrupt lines: bit 0 = 2/9, 1 = 3, 2 = 4, 3 = 5
  output logic [3:0] irq_out,
  output logic [3:0] irq_oe,
  output logic irq_pulldown_en,
  // host dma channels 1 and 3
  output logic drq1_out,
  output logic drq1_oe,
  output logic drq3_out,
  output logic drq3_oe,
  input wire logic dack1_n,
  input wire logic dack3_n
);

  // synchronised pins; strobes and acknowledges are inverted first so that
  // the reset value of the synchroniser reads as idle
  logic [9:0] addr_s;
  logic aen_s;
  logic ior_s;
  logic iow_s;
  logic [7:0] data_s;
  logic [6:0] sw_s;
  logic [3:0] irqsel_s;
  logic shared_s;
  logic [6:1] ack_hdr_s;
  logic [6:1] req_hdr_s;
  logic [1:0] gate_s;
  logic dsr_a_s;
  logic dsr_b_s;
  logic dack1_s;
  logic dack3_s;

  scbg_sync #(.W(21)) u_sync_bus (
    .clk(clk),
    .rst(rst),
    .d({host_addr, host_aen, ~host_ior_n, ~host_iow_n, host_data_in}),
    .q({addr_s, aen_s, ior_s, iow_s, data_s})
  );

  scbg_sync #(.W(26)) u_sync_strap (
    .clk(clk),
    .rst(rst),
    .d({base_address_switch, irq_select_header, irq_shared_sel, dma_ack_route_header,
        dma_request_route_header, dma_driver_gate_header}),
    .q({sw_s, irqsel_s, shared_s, ack_hdr_s, req_hdr_s, gate_s})
  );

  scbg_sync #(.W(4)) u_sync_misc (
    .clk(clk),
    .rst(rst),
    .d({dsr_a, dsr_b, ~dack1_n, ~dack3_n}),
    .q({dsr_a_s, dsr_b_s, dack1_s, dack3_s})
  );

  scbg_pkg::scbg_state_t s_r;
  scbg_pkg::scbg_state_t s_nxt;

  // window decode
  logic hit;
  logic [2:0] ofs;
  assign hit = !aen_s && (addr_s[9:3] == ~sw_s) && (addr_s[9:8] != `SCBG_BASE_HI_NONE); // RULE_01 RULE_02 RULE_03 RULE_04
  assign ofs = addr_s[2:0];
  assign card_hit = hit;

  // dma mode from the routing headers; an inconsistent mix falls to the
  // nearest listed mode rather than driving two sources onto one line
  scbg_pkg::scbg_dma_mode_t mode;
  logic b_en;
  logic full;
  assign full = req_hdr_s[6];
  assign b_en = req_hdr_s[5] && !full; // RULE_13

  always_comb begin
    mode = scbg_pkg::DM_NONE; // RULE_19
    if (full) begin
      mode = req_hdr_s[4] ? scbg_pkg::DM_FULL_RX1 : scbg_pkg::DM_FULL_RX3; // RULE_10
    end else if (ack_hdr_s[1] && ack_hdr_s[2] && b_en) begin
      mode = scbg_pkg::DM_SPLIT_SPLIT_DMA_A_HIGH; // RULE_11
    end else if (ack_hdr_s[1] && ack_hdr_s[3] && b_en) begin
      mode = scbg_pkg::DM_SPLIT_SPLIT_DMA_A_LOW; // RULE_11
    end else if (ack_hdr_s[4]) begin
      if (req_hdr_s[4] || req_hdr_s[3]) begin
        mode = scbg_pkg::DM_HALF_A1;
      end else if (req_hdr_s[2] || req_hdr_s[1]) begin
        mode = scbg_pkg::DM_HALF_A3;
      end
    end else if (b_en) begin
      if (req_hdr_s[3]) begin
        mode = scbg_pkg::DM_HALF_B1; // RULE_13
      end else if (req_hdr_s[1]) begin
        mode = scbg_pkg::DM_HALF_B3; // RULE_13
      end
    end
  end

  // dma drivers: jumper 1 forces on, jumper 2 hands control to bit 7
  logic drv_en;
  assign drv_en = gate_s[0] || (gate_s[1] && s_r.dma_en); // RULE_14 RULE_15 RULE_16 RULE_18

  // single request per channel in half duplex; a's second request only in full
  logic src1;
  logic src3;
  logic use1;
  logic use3;
  logic ack1_a;
  logic ack3_a;
  always_comb begin
    src1 = 1'b0;
    src3 = 1'b0;
    use1 = 1'b1;
    use3 = 1'b1;
    ack1_a = 1'b1;
    ack3_a = 1'b1;
    case (mode)
      scbg_pkg::DM_HALF_A1: begin
        src1 = sc_req_a; // RULE_09
        use3 = 1'b0;
      end
      scbg_pkg::DM_HALF_A3: begin
        src3 = sc_req_a; // RULE_09
        use1 = 1'b0;
      end
      scbg_pkg::DM_HALF_B1: begin
        src1 = sc_req_b;
        use3 = 1'b0;
        ack1_a = 1'b0;
      end
      scbg_pkg::DM_HALF_B3: begin
        src3 = sc_req_b;
        use1 = 1'b0;
        ack3_a = 1'b0;
      end
      scbg_pkg::DM_SPLIT_SPLIT_DMA_A_HIGH: begin
        src1 = sc_req_b;
        src3 = sc_req_a;
        ack1_a = 1'b0;
      end
      scbg_pkg::DM_SPLIT_SPLIT_DMA_A_LOW: begin
        src1 = sc_req_a;
        src3 = sc_req_b;
        ack3_a = 1'b0;
      end
      scbg_pkg::DM_FULL_RX1: begin
        src1 = sc_req_a; // RULE_10
        src3 = sc_dtr_req_a;
      end
      scbg_pkg::DM_FULL_RX3: begin
        src1 = sc_dtr_req_a; // RULE_10
        src3 = sc_req_a;
      end
      default: begin
        use1 = 1'b0;
        use3 = 1'b0;
      end
    endcase
  end

  // lowest fitted interrupt jumper wins so only one line is ever driven
  logic [3:0] irq_sel;
  always_comb begin
    irq_sel = 4'h0;
    for (int i = 3; i >= 0; i--) begin
      if (irqsel_s[i]) begin
        irq_sel = 4'h1 << i; // RULE_07
      end
    end
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.sc_wr = 1'b0;
    case (s_r.phase)
      scbg_pkg::PH_IDLE: begin
        if (hit && iow_s) begin
          s_nxt.phase = scbg_pkg::PH_HOLD;
          if (ofs < `SCBG_OFS_BOARD_CS) begin
            s_nxt.sc_wr = 1'b1; // RULE_05
            s_nxt.sc_addr = ofs[1:0];
            s_nxt.sc_wdata = data_s;
          end else if (ofs == `SCBG_OFS_BOARD_CS) begin
            s_nxt.dtr_a = data_s[`SCBG_BIT_DTR_A]; // RULE_06 RULE_21
            s_nxt.dtr_b = data_s[`SCBG_BIT_DTR_B]; // RULE_21
            s_nxt.dma_en = data_s[`SCBG_BIT_DMA_EN]; // RULE_20
          end
        end else if (hit && ior_s) begin
          s_nxt.phase = scbg_pkg::PH_READ;
          s_nxt.rd_ofs = ofs;
          s_nxt.sc_addr = (ofs < `SCBG_OFS_BOARD_CS) ? ofs[1:0] : s_r.sc_addr;
        end
      end
      scbg_pkg::PH_READ: begin
        if (!ior_s || !hit) begin
          s_nxt.phase = scbg_pkg::PH_IDLE;
        end
      end
      scbg_pkg::PH_HOLD: begin
        // one write per strobe, however long the host holds it
        if (!iow_s) begin
          s_nxt.phase = scbg_pkg::PH_IDLE;
        end
      end
      default: begin
        s_nxt.phase = scbg_pkg::PH_IDLE;
      end
    endcase
    s_nxt.sc_rd = (s_nxt.phase == scbg_pkg::PH_READ) && (s_nxt.rd_ofs < `SCBG_OFS_BOARD_CS);
    s_nxt.data_oe = (s_nxt.phase == scbg_pkg::PH_READ) && (s_nxt.rd_ofs <= `SCBG_OFS_BOARD_CS); // RULE_22
    s_nxt.data_out = 8'h00;
    if (s_nxt.sc_rd) begin
      s_nxt.data_out = sc_rdata;
    end else if (s_nxt.data_oe) begin
      s_nxt.data_out[`SCBG_BIT_DTR_A] = dsr_a_s; // RULE_21
      s_nxt.data_out[`SCBG_BIT_DTR_B] = dsr_b_s; // RULE_21
    end
    s_nxt.drq1_oe = drv_en && use1; // RULE_16
    s_nxt.drq3_oe = drv_en && use3;
    s_nxt.drq1 = drv_en && use1 && src1;
    s_nxt.drq3 = drv_en && use3 && src3;
    s_nxt.dack_a = drv_en && ((use1 && ack1_a && dack1_s) || (use3 && ack3_a && dack3_s)); // RULE_12
    s_nxt.dack_b = drv_en && ((use1 && !ack1_a && dack1_s) || (use3 && !ack3_a && dack3_s)); // RULE_12 RULE_13
    s_nxt.irq_out = irq_sel & {4{sc_irq}};
    s_nxt.irq_oe = shared_s ? (irq_sel & {4{sc_irq}}) : irq_sel; // RULE_08
    s_nxt.irq_pulldown_en = shared_s; // RULE_08
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
      s_r.dma_en <= `SCBG_RST_DMA_EN; // RULE_17
      s_r.dtr_a <= `SCBG_RST_DTR;
      s_r.dtr_b <= `SCBG_RST_DTR;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign host_data_out = s_r.data_out;
  assign host_data_oe = s_r.data_oe;
  assign sc_wr = s_r.sc_wr;
  assign sc_rd = s_r.sc_rd;
  assign sc_addr = s_r.sc_addr;
  assign sc_wdata = s_r.sc_wdata;
  assign sc_dack_a = s_r.dack_a;
  assign sc_dack_b = s_r.dack_b;
  assign dtr_a = s_r.dtr_a;
  assign dtr_b = s_r.dtr_b;
  assign irq_out = s_r.irq_out;
  assign irq_oe = s_r.irq_oe;
  assign irq_pulldown_en = s_r.irq_pulldown_en;
  assign drq1_out = s_r.drq1;
  assign drq1_oe = s_r.drq1_oe;
  assign drq3_out = s_r.drq3;
  assign drq3_oe = s_r.drq3_oe;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic board_wr;
  assign board_wr = (s_r.phase == scbg_pkg::PH_IDLE) && hit && iow_s && (ofs == `SCBG_OFS_BOARD_CS);

  chk_window_match: assert property ($rose(s_r.sc_wr) |-> $past(addr_s[9:3]) == ~$past(sw_s)) // RULE_03
    else $error("serial write outside the switch-selected window");
  chk_base_range: assert property (s_r.sc_wr |-> $past(addr_s[9:8]) != `SCBG_BASE_HI_NONE) // RULE_02
    else $error("serial write decoded below the lowest base");
  chk_port_map: assert property (s_r.sc_wr |-> s_r.sc_addr == $past(addr_s[1:0]) && !$past(addr_s[2])) // RULE_05
    else $error("serial port index does not follow the offset");
  chk_board_store: assert property (board_wr |=> s_r.dma_en == $past(data_s[7]) && !s_r.sc_wr) // RULE_20
    else $error("board write did not store the dma enable");
  chk_dtr_store: assert property (board_wr |=> s_r.dtr_a == $past(data_s[0]) ##1 $stable(dtr_a)) // RULE_21
    else $error("terminal-ready a does not follow the board write");
  chk_gap_quiet: assert property ((s_r.phase == scbg_pkg::PH_IDLE) && hit && iow_s && ofs > 3'h4
    |=> $stable(s_r.dma_en) && $stable(s_r.dtr_b) && !s_r.sc_wr ##1 !host_data_oe) // RULE_22
    else $error("access above offset 4 had an effect");
  chk_perm_enable: assert property (gate_s[0] && use1 |=> drq1_oe) // RULE_14
    else $error("permanent enable did not turn the driver on");
  chk_driver_gate: assert property (drq1_oe || drq3_oe |-> $past(gate_s[0] || (gate_s[1] && s_r.dma_en))) // RULE_15
    else $error("dma driver on without an enable");
  chk_irq_single: assert property ($onehot0(irq_oe) && (irq_out & ~$past(irq_sel)) == 4'h0) // RULE_07
    else $error("more than one interrupt line driven");
  chk_b_half: assert property (sc_dack_b |-> $past(b_en)) // RULE_13
    else $error("channel b acknowledged outside half duplex");
  chk_reset_dma: assert property (@(posedge clk) disable iff (1'b0) rst |=> !s_r.dma_en) // RULE_17
    else $error("dma enable not cleared by reset");

  cov_board_write: cover property (board_wr ##1 s_r.dma_en);
  cov_serial_read: cover property (s_r.sc_rd && host_data_oe);
  cov_full_duplex: cover property (mode == scbg_pkg::DM_FULL_RX1 && drq1_out ##1 drq3_out);
  cov_split: cover property (mode == scbg_pkg::DM_SPLIT_SPLIT_DMA_A_HIGH && sc_dack_b);

endmodule : scbg_glue

/* File: scbg_host_model.sv */
// host processor and dma controller stand-in for the serial card bus glue
// assumes the glue synchronises every host pin, so i/o cycles are stretched
`timescale 1ns/100ps
module scbg_host_model (
  // clock
  input wire logic clk,
  // host i/o bus
  output logic [9:0] host_addr,
  output logic host_aen,
  output logic host_ior_n,
  output logic host_iow_n,
  output logic [7:0] host_data_in,
  input wire logic [7:0] host_data_out,
  input wire logic host_data_oe,
  // dma acknowledges
  output logic dack1_n,
  output logic dack3_n
);
  initial begin
    host_addr = 10'h000;
    host_aen = 1'b0;
    host_ior_n = 1'b1;
    host_iow_n = 1'b1;
    host_data_in = 8'h00;
    dack1_n = 1'b1;
    dack3_n = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask : hold

  task automatic park(input logic [9:0] a);
    @(posedge clk);
    host_addr <= a;
    hold(4);
    #1;
  endtask : park

  // six cycles low covers two sync stages plus decode; six high keeps accesses apart
  task automatic io_wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    host_addr <= a;
    host_data_in <= d;
    host_iow_n <= 1'b0;
    hold(6);
    host_iow_n <= 1'b1;
    host_data_in <= ~d; // released bus must not look like the last value
    hold(6);
  endtask : io_wr

  task automatic io_rd(input logic [9:0] a, output logic [7:0] d, output logic oe);
    @(posedge clk);
    host_addr <= a;
    host_ior_n <= 1'b0;
    hold(6);
    d = host_data_out;
    oe = host_data_oe;
    host_ior_n <= 1'b1;
    hold(6);
  endtask : io_rd

  // bit 0 acknowledges dma 1, bit 1 dma 3; lines are active low
  task automatic ack(input logic [1:0] n);
    dack1_n <= ~n[0];
    dack3_n <= ~n[1];
  endtask : ack
endmodule : scbg_host_model

/* File: test_serial_card_bus_glue.sv */
// self-checking bench of the serial card bus glue
// assumes the host model owns the host pins; straps and controller pins are driven here
`timescale 1ns/100ps
module test_serial_card_bus_glue;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] host_addr;
  logic host_aen, host_ior_n, host_iow_n, host_data_oe, card_hit, dack1_n, dack3_n;
  logic [7:0] host_data_in, host_data_out, sc_wdata, sc_rdata, rd_d;
  logic [6:0] base_address_switch;
  logic [3:0] irq_select_header, irq_out, irq_oe;
  logic irq_shared_sel, sc_wr, sc_rd, sc_irq, sc_req_a, sc_dtr_req_a, sc_req_b, rd_oe;
  logic [6:1] dma_ack_route_header, dma_request_route_header;
  logic [1:0] dma_driver_gate_header, sc_addr, wr_a;
  logic sc_dack_a, sc_dack_b, dtr_a, dtr_b, dsr_a, dsr_b, irq_pulldown_en;
  logic drq1_out, drq1_oe, drq3_out, drq3_oe;
  logic [7:0] wr_d;
  int wr_cnt = 0;
  int rd_cnt = 0;
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;

  always #2 clk = ~clk;

  scbg_glue DUT (.clk, .rst, .host_addr, .host_aen, .host_ior_n, .host_iow_n, .host_data_in,
    .host_data_out, .host_data_oe, .card_hit, .base_address_switch, .irq_select_header,
    .irq_shared_sel, .dma_ack_route_header, .dma_request_route_header, .dma_driver_gate_header,
    .sc_wr, .sc_rd, .sc_addr, .sc_wdata, .sc_rdata, .sc_irq, .sc_req_a, .sc_dtr_req_a, .sc_req_b,
    .sc_dack_a, .sc_dack_b, .dtr_a, .dtr_b, .dsr_a, .dsr_b, .irq_out, .irq_oe, .irq_pulldown_en,
    .drq1_out, .drq1_oe, .drq3_out, .drq3_oe, .dack1_n, .dack3_n);

  scbg_host_model host (.clk, .host_addr, .host_aen, .host_ior_n, .host_iow_n, .host_data_in,
    .host_data_out, .host_data_oe, .dack1_n, .dack3_n);

  // write strobe pulses last one cycle, read strobes span the read; catch them mid-cycle
  always @(negedge clk) begin
    if (sc_wr === 1'b1) begin
      wr_cnt++;
      wr_a = sc_addr;
      wr_d = sc_wdata;
    end
    if (sc_rd === 1'b1) begin
      rd_cnt++;
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      conclude();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic look(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : look

  function automatic logic [6:0] sw_of(input logic [9:0] b);
    return ~b[9:3];
  endfunction : sw_of

  task automatic t_decode();
    logic [9:0] b [3] = '{10'h100, 10'h3f8, 10'h238};
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      base_address_switch <= sw_of(b[i]);
      host.park(b[i]);
      chk(card_hit, 1);
      host.park(b[i] + 10'h007);
      chk(card_hit, 1);
      host.park(b[i] + 10'h008);
      chk(card_hit, 0);
      host.park(b[i] - 10'h001);
      chk(card_hit, 0);
    end
    @(posedge clk);
    base_address_switch <= sw_of(10'h0f8);
    host.park(10'h0f8);
    chk(card_hit, 0);
    @(posedge clk);
    base_address_switch <= sw_of(10'h238);
    $display("test decode done");
  endtask : t_decode

  task automatic t_ports();
    int wc;
    int rc;
    for (int i = 0; i < 4; i++) begin
      wc = wr_cnt;
      host.io_wr(10'h238 + i, 8'h5a + i);
      chk(wr_cnt - wc, 1);
      chk(wr_a, i);
      chk(wr_d, 8'h5a + i);
      @(posedge clk);
      sc_rdata <= 8'hc3 ^ i;
      rc = rd_cnt;
      host.io_rd(10'h238 + i, rd_d, rd_oe);
      chk({rd_oe, rd_d}, {1'b1, 8'hc3 ^ 8'(i)});
      chk(rd_cnt != rc, 1);
    end
    wc = wr_cnt;
    host.io_wr(10'h23c, 8'h01);
    chk({dtr_b, dtr_a}, 2'b01);
    host.io_wr(10'h23c, 8'h02);
    chk({dtr_b, dtr_a}, 2'b10);
    chk(wr_cnt - wc, 0);
    @(posedge clk);
    dsr_a <= 1'b1;
    rc = rd_cnt;
    host.io_rd(10'h23c, rd_d, rd_oe);
    chk({rd_oe, rd_d}, 9'h101);
    chk(rd_cnt == rc, 1);
    for (int i = 5; i < 8; i++) begin
      host.io_wr(10'h238 + i, 8'h01);
      host.io_rd(10'h238 + i, rd_d, rd_oe);
      chk(rd_oe, 0);
    end
    chk({dtr_b, dtr_a}, 2'b10);
    chk(wr_cnt - wc, 0);
    $display("test ports done");
  endtask : t_ports

  task automatic t_gate();
    logic [10:0] row [5] = '{{2'b10, 8'h80, 1'b1}, {2'b10, 8'h00, 1'b0}, {2'b01, 8'h00, 1'b1},
      {2'b00, 8'h80, 1'b0}, {2'b11, 8'h00, 1'b1}};
    @(posedge clk);
    dma_ack_route_header <= 6'b101000;
    dma_request_route_header <= 6'b011000;
    sc_req_a <= 1'b1;
    host.ack(2'b01);
    look(5);
    chk({drq1_oe, sc_dack_a}, 2'b00);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      dma_driver_gate_header <= row[i][10:9];
      host.io_wr(10'h23c, row[i][8:1]);
      look(5);
      chk({drq1_oe, drq1_out & drq1_oe, sc_dack_a}, {3{row[i][0]}});
    end
    @(posedge clk);
    dma_driver_gate_header <= 2'b10;
    host.io_wr(10'h23c, 8'h81);
    look(5);
    chk({drq1_oe, dtr_a}, 2'b11);
    // reset in mid-run must drop the software enable again
    @(posedge clk);
    rst <= 1'b1;
    look(2);
    @(posedge clk);
    rst <= 1'b0;
    look(5);
    chk({drq1_oe, sc_dack_a, dtr_a}, 3'b000);
    host.ack(2'b00);
    $display("test gate done");
  endtask : t_gate

  task automatic t_route();
    // ack, request, {req_a, dtr_req_a, req_b}, dack {3,1}, drq {3,1}, dack {b,a}
    logic [20:0] row [10] = '{
      {6'b101000, 6'b011000, 3'b110, 2'b01, 2'b01, 2'b01},
      {6'b000011, 6'b010110, 3'b100, 2'b01, 2'b10, 2'b10},
      {6'b000101, 6'b011001, 3'b100, 2'b01, 2'b01, 2'b01},
      {6'b001001, 6'b101001, 3'b110, 2'b10, 2'b11, 2'b01},
      {6'b100000, 6'b000100, 3'b001, 2'b01, 2'b00, 2'b00},
      {6'b000000, 6'b000000, 3'b111, 2'b11, 2'b00, 2'b00},
      {6'b100000, 6'b010100, 3'b001, 2'b01, 2'b01, 2'b10},
      {6'b010000, 6'b010001, 3'b001, 2'b10, 2'b10, 2'b10},
      {6'b001000, 6'b000010, 3'b100, 2'b10, 2'b10, 2'b01},
      {6'b001001, 6'b100110, 3'b010, 2'b10, 2'b01, 2'b01}};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      dma_driver_gate_header <= 2'b01;
      dma_ack_route_header <= row[i][20:15];
      dma_request_route_header <= row[i][14:9];
      {sc_req_a, sc_dtr_req_a, sc_req_b} <= row[i][8:6];
      host.ack(row[i][5:4]);
      look(6);
      chk({drq3_out, drq1_out}, row[i][3:2]);
      chk({sc_dack_b, sc_dack_a}, row[i][1:0]);
      host.ack(2'b00);
    end
    $display("test route done");
  endtask : t_route

  task automatic t_irq();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      irq_select_header <= 4'h1 << i;
      irq_shared_sel <= 1'b0;
      sc_irq <= 1'b1;
      look(4);
      chk({irq_pulldown_en, irq_oe, irq_out & irq_oe}, {1'b0, {2{4'h1 << i}}});
      @(posedge clk);
      irq_shared_sel <= 1'b1;
      sc_irq <= 1'b0;
      look(4);
      chk({irq_pulldown_en, irq_oe}, 5'h10);
      @(posedge clk);
      sc_irq <= 1'b1;
      look(2);
      chk(irq_oe, 4'h1 << i);
    end
    $display("test irq done");
  endtask : t_irq

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  initial begin
    base_address_switch = sw_of(10'h238);
    irq_select_header = 4'h0;
    irq_shared_sel = 1'b0;
    dma_ack_route_header = 6'h00;
    dma_request_route_header = 6'h00;
    dma_driver_gate_header = 2'b10;
    sc_rdata = 8'h00;
    sc_irq = 1'b0;
    sc_req_a = 1'b0;
    sc_dtr_req_a = 1'b0;
    sc_req_b = 1'b0;
    dsr_a = 1'b0;
    dsr_b = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    look(4);
    t_gate();
    t_decode();
    t_ports();
    t_route();
    t_irq();
    conclude();
  end
endmodule : test_serial_card_bus_glue
